// ### rtl/lcd_host_port.sv
`timescale 1ns/1ns
`include "lcd_port_defines.svh"
module lcd_host_port (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        HOST_CS_B_IN,
  input  wire logic        HOST_AS_B_IN,
  input  wire logic        HOST_DS_IN,
  input  wire logic        HOST_RW_IN,
  input  wire logic [15:0] HOST_ADDRESS_LINES_IN,
  input  wire logic [7:0]  HOST_DATA_IN,
  output logic      [7:0]  HOST_DATA_OUT,
  output logic             HOST_DATA_OE_B_OUT,
  output logic             HOST_ACK_OUT,
  output logic             HOST_ACK_OE_B_OUT,
  input  wire logic        ACCESS_MODE_STRAP_IN,
  input  wire logic        BUS_FAMILY_STRAP_IN,
  input  wire logic        PIN_FUNCTION_STRAP_IN,
  input  wire logic [7:0]  MEM_RDATA_IN,
  output logic             MEM_FETCH_PULSE_OUT,
  output logic             EVT_VALID_OUT,
  input  wire logic        EVT_READY_IN,
  output logic      [1:0]  EVT_KIND_OUT,
  output logic      [7:0]  EVT_CODE_OUT,
  output logic      [3:0]  EVT_INDEX_OUT,
  output logic      [7:0]  EVT_DATA_OUT,
  output logic             DISPLAY_ON_OUT,
  output logic             SLEEP_OUT,
  output logic      [1:0]  CURSOR_DIR_OUT,
  output logic             GRAYSCALE_OUT,
  output logic      [15:0] CURSOR_ADDR_OUT
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 31;
  localparam logic [NPIN-1:0] PIN_IDLE = 31'h0000000f;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] f_q;

  assign pin_raw = {ACCESS_MODE_STRAP_IN, BUS_FAMILY_STRAP_IN, PIN_FUNCTION_STRAP_IN,
                    HOST_DATA_IN, HOST_ADDRESS_LINES_IN,
                    HOST_RW_IN, HOST_DS_IN, HOST_AS_B_IN, HOST_CS_B_IN};

  // A change counts only once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
          s1_q[gi] <= PIN_IDLE[gi];
          s2_q[gi] <= PIN_IDLE[gi];
          s3_q[gi] <= PIN_IDLE[gi];
          f_q[gi]  <= PIN_IDLE[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            f_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic        cs_b_f;
  logic        as_b_f;
  logic        ds_f;
  logic        rw_f;
  logic [15:0] addr_f;
  logic [7:0]  data_f;

  assign cs_b_f = f_q[0];
  assign as_b_f = f_q[1];
  assign ds_f   = f_q[2];
  assign rw_f   = f_q[3];
  assign addr_f = f_q[19:4];
  assign data_f = f_q[27:20];

  // ****************************************
  // Straps, caught once after reset
  // ****************************************
  // The filter output only settles on the fourth edge, so the latch waits one more
  logic [2:0] strap_cnt_q;
  logic       straps_ok_q;
  logic       access_mode_q;
  logic       bus_family_q;
  logic       pin_function_q;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      strap_cnt_q    <= 3'h0;
      straps_ok_q    <= 1'b0;
      access_mode_q  <= 1'b0;
      bus_family_q   <= 1'b0;
      pin_function_q <= 1'b0;
    end else if (!straps_ok_q) begin
      if (strap_cnt_q == 3'(`STRAP_SETTLE)) begin
        straps_ok_q    <= 1'b1;
        access_mode_q  <= f_q[30];
        bus_family_q   <= f_q[29];
        pin_function_q <= f_q[28];
      end else begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Bus cycle decode
  // ****************************************
  logic access;
  logic is_read;
  logic as_act;
  logic strobe;

  // Without the address strobe pin in use the cycle is framed by select and strobes alone
  assign as_act  = pin_function_q ? ~as_b_f : 1'b1;
  assign strobe  = bus_family_q ? ds_f : (~ds_f | ~rw_f);
  assign is_read = bus_family_q ? rw_f : (~ds_f & rw_f);
  assign access  = straps_ok_q & ~cs_b_f & as_act & strobe;

  logic [7:0]  cur_cmd_q;
  logic [3:0]  param_idx_q;
  logic [15:0] cursor_q;
  logic        rd_hi_q;
  logic        pop_cmd;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [8:0]  fifo_out_data;
  logic        push_q;
  logic [8:0]  push_word_q;
  logic [7:0]  rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (access_mode_q) begin
      if (addr_f[0]) begin
        if (cur_cmd_q == `CMD_CURSOR_GET) begin
          rd_mux = rd_hi_q ? cursor_q[15:8] : cursor_q[7:0];
        end else begin
          rd_mux = MEM_RDATA_IN;
        end
      end
    end else if (addr_f == `DIRECT_CMD_ADDR) begin
      rd_mux = cur_cmd_q;
    end else if (addr_f == `DIRECT_IDX_ADDR) begin
      rd_mux = {4'h0, param_idx_q};
    end
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  lcd_port_pkg::bus_state_t state_q;
  logic [3:0] cyc_q;
  logic [3:0] min_len_q;
  logic       last_wr_q;
  logic       rd_done;

  // Reads wait until every earlier write has been decoded, keeping order
  assign rd_done = (state_q == lcd_port_pkg::ST_RD_WAIT) && access &&
                   (cyc_q >= 4'(`RD_DRIVE_CYC)) && !fifo_out_valid && !push_q;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      state_q            <= lcd_port_pkg::ST_IDLE;
      cyc_q              <= 4'hf;
      min_len_q          <= 4'h0;
      last_wr_q          <= 1'b0;
      HOST_ACK_OUT       <= 1'b1;
      HOST_ACK_OE_B_OUT  <= 1'b1;
      HOST_DATA_OUT      <= 8'h00;
      HOST_DATA_OE_B_OUT <= 1'b1;
      push_q             <= 1'b0;
      push_word_q        <= 9'h000;
    end else begin
      if (cyc_q != 4'hf) begin
        cyc_q <= cyc_q + 4'h1;
      end
      if (push_q && fifo_in_ready) begin
        push_q <= 1'b0;
      end
      case (state_q)
        lcd_port_pkg::ST_IDLE: begin
          if (access && cyc_q >= min_len_q) begin
            cyc_q             <= 4'h1;
            HOST_ACK_OUT      <= 1'b1;
            HOST_ACK_OE_B_OUT <= 1'b0;
            if (is_read) begin
              min_len_q <= last_wr_q ? 4'(`CYC_MIN_WR_RD) : 4'(`CYC_MIN_READ);
              state_q   <= lcd_port_pkg::ST_RD_WAIT;
            end else begin
              min_len_q <= 4'(`CYC_MIN_WRITE);
              state_q   <= lcd_port_pkg::ST_WR_WAIT;
            end
            last_wr_q <= ~is_read;
          end
        end
        lcd_port_pkg::ST_RD_WAIT: begin
          if (!access) begin
            HOST_ACK_OE_B_OUT <= 1'b1;
            state_q           <= lcd_port_pkg::ST_IDLE;
          end else if (rd_done) begin
            HOST_DATA_OUT      <= rd_mux;
            HOST_DATA_OE_B_OUT <= 1'b0;
            HOST_ACK_OUT       <= 1'b0;
            state_q            <= lcd_port_pkg::ST_ACKED;
          end
        end
        lcd_port_pkg::ST_WR_WAIT: begin
          if (!access && !push_q) begin
            HOST_ACK_OE_B_OUT <= 1'b1;
            state_q           <= lcd_port_pkg::ST_IDLE;
          end else if (cyc_q == 4'(`WR_SAMPLE_EDGE - 1) && !push_q) begin
            push_q      <= 1'b1;
            push_word_q <= {access_mode_q ? addr_f[0] : (addr_f == `DIRECT_CMD_ADDR), data_f};
          end else if (push_q && fifo_in_ready) begin
            HOST_ACK_OUT <= 1'b0;
            state_q      <= lcd_port_pkg::ST_ACKED;
          end
        end
        lcd_port_pkg::ST_ACKED: begin
          if (!access) begin
            HOST_ACK_OUT       <= 1'b1;
            HOST_DATA_OE_B_OUT <= 1'b1;
            state_q            <= lcd_port_pkg::ST_RELEASE;
          end
        end
        lcd_port_pkg::ST_RELEASE: begin
          HOST_ACK_OE_B_OUT <= 1'b1;
          state_q           <= lcd_port_pkg::ST_IDLE;
        end
        default: begin
          state_q <= lcd_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Fifo back-pressure holds acknowledge off, so a busy decoder stalls the host
  port_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (SYS_CLK_IN),
    .rst_b_in      (RST_B_IN),
    .in_valid_in   (push_q),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_word_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  // ****************************************
  // Command decoder
  // ****************************************
  function automatic logic [3:0] param_limit(input logic [7:0] code);
    logic [3:0] n;
    n = 4'h0;
    case (code)
      `CMD_SYSTEM_SETUP:                 n = 4'h8;
      `CMD_DISPLAY_OFF, `CMD_DISPLAY_ON: n = 4'h1;
      `CMD_DISPLAY_AREA:                 n = 4'ha;
      `CMD_CURSOR_SHAPE:                 n = 4'h2;
      `CMD_GLYPH_BASE:                   n = 4'h2;
      `CMD_FINE_SHIFT:                   n = 4'h1;
      `CMD_LAYER_COMBINE:                n = 4'h1;
      `CMD_CURSOR_SET:                   n = 4'h2;
      default:                           n = 4'h0;
    endcase
    return n;
  endfunction : param_limit

  logic       is_stream;
  logic [7:0] pop_byte;

  assign fifo_out_ready = ~EVT_VALID_OUT | EVT_READY_IN;
  assign pop_cmd        = fifo_out_valid & fifo_out_ready & fifo_out_data[8];
  assign pop_byte       = fifo_out_data[7:0];
  assign is_stream      = (cur_cmd_q == `CMD_MEMORY_STORE) || (cur_cmd_q == `CMD_MEMORY_FETCH);

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      EVT_VALID_OUT  <= 1'b0;
      EVT_KIND_OUT   <= lcd_port_pkg::EVT_CMD;
      EVT_CODE_OUT   <= 8'h00;
      EVT_INDEX_OUT  <= 4'h0;
      EVT_DATA_OUT   <= 8'h00;
      cur_cmd_q      <= 8'h00;
      param_idx_q    <= 4'h0;
      cursor_q       <= 16'h0000;
      DISPLAY_ON_OUT <= 1'b0;
      SLEEP_OUT      <= 1'b0;
      CURSOR_DIR_OUT <= 2'h0;
      GRAYSCALE_OUT  <= 1'b0;
    end else begin
      if (EVT_READY_IN) begin
        EVT_VALID_OUT <= 1'b0;
      end
      if (fifo_out_valid && fifo_out_ready) begin
        EVT_VALID_OUT <= 1'b1;
        EVT_DATA_OUT  <= pop_byte;
        if (fifo_out_data[8]) begin
          // A new code drops whatever remains of the previous list
          cur_cmd_q     <= pop_byte;
          param_idx_q   <= 4'h0;
          EVT_KIND_OUT  <= lcd_port_pkg::EVT_CMD;
          EVT_CODE_OUT  <= pop_byte;
          EVT_INDEX_OUT <= 4'h0;
          if (pop_byte == `CMD_SLEEP) begin
            SLEEP_OUT <= 1'b1;
          end else if (pop_byte == `CMD_SYSTEM_SETUP) begin
            SLEEP_OUT <= 1'b0;
          end
          if (pop_byte[7:1] == 7'(`CMD_DISPLAY_OFF >> 1)) begin
            DISPLAY_ON_OUT <= pop_byte[0];
          end
          if (pop_byte[7:2] == 6'(`CMD_CURSOR_DIR_BASE >> 2)) begin
            CURSOR_DIR_OUT <= pop_byte[1:0];
          end
          if (pop_byte == `CMD_GRAYSCALE) begin
            GRAYSCALE_OUT <= 1'b1;
          end
        end else begin
          EVT_CODE_OUT  <= cur_cmd_q;
          EVT_INDEX_OUT <= param_idx_q;
          if (is_stream) begin
            EVT_KIND_OUT <= lcd_port_pkg::EVT_DATA;
          end else if (param_idx_q < param_limit(cur_cmd_q)) begin
            EVT_KIND_OUT <= lcd_port_pkg::EVT_PARAM;
            param_idx_q  <= param_idx_q + 4'h1;
            if (cur_cmd_q == `CMD_CURSOR_SET) begin
              if (param_idx_q == 4'h0) begin
                cursor_q[7:0] <= pop_byte;
              end else begin
                cursor_q[15:8] <= pop_byte;
              end
            end
          end else begin
            EVT_KIND_OUT <= lcd_port_pkg::EVT_EXTRA;
          end
        end
      end
    end
  end

  assign CURSOR_ADDR_OUT = cursor_q;

  // ****************************************
  // Read-side bookkeeping
  // ****************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      rd_hi_q             <= 1'b0;
      MEM_FETCH_PULSE_OUT <= 1'b0;
    end else begin
      MEM_FETCH_PULSE_OUT <= 1'b0;
      if (pop_cmd) begin
        rd_hi_q <= 1'b0;
      end else if (rd_done && access_mode_q && addr_f[0]) begin
        if (cur_cmd_q == `CMD_CURSOR_GET) begin
          rd_hi_q <= ~rd_hi_q;
        end else if (cur_cmd_q == `CMD_MEMORY_FETCH) begin
          MEM_FETCH_PULSE_OUT <= 1'b1;
        end
      end
    end
  end

endmodule : lcd_host_port

// ### rtl/lcd_port_defines.svh
// Function
// - On chip select plus address strobe drive acknowledge, raise after strobe ends, release next clock.
// - A read drives the data bus no sooner than three clocks plus 9 ns.
// - Read data is valid before the second falling clock edge after acknowledge falls.
// - Cycles last at least 7 read, 8 write-write, 11 write-read clocks.
// - Straps reassign two bus pins to suit either processor bus family.
// - Bus family strap high selects direction-plus-enable, low selects split strobes.
// - Direct mode decodes the full address; read strobe alone reads registers.
// - Direct mode direction high reads, direction low with enable writes.
// - Indirect mode decodes only the select bit for data reads and writes.
// - Indirect write with select bit high is a command code.
// - Code 40h is system setup with eight parameters; 53h is sleep.
// - Codes 58h/59h switch display by bit zero, one flashing parameter.
// - Code 44h takes ten parameters; 5Dh cursor shape takes two.
// - Codes 4Ch to 4Fh set cursor direction from the low bits.
// - 5Ch two parameters, 5Ah one, 5Bh one, 60h grayscale none.
// - 46h sets cursor with two parameters; 47h reads back two bytes.
// - 42h and 43h stream display memory data without bound.
// - Each parameter acts at once; a new command cuts a list short.
`ifndef LCD_PORT_DEFINES_SVH
`define LCD_PORT_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS       8
`define RD_DRIVE_CLKS       3
`define RD_DRIVE_EXTRA_NS   9
`define RD_DRIVE_CYC        ((`RD_DRIVE_CLKS*`CLK_PERIOD_NS+`RD_DRIVE_EXTRA_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define WR_SAMPLE_EDGE      4
`define CYC_MIN_READ        7
`define CYC_MIN_WRITE       8
`define CYC_MIN_WR_RD       11
`define STRAP_SETTLE        4

// ****************************************
// Command codes
// ****************************************
`define CMD_SYSTEM_SETUP    8'h40
`define CMD_MEMORY_STORE    8'h42
`define CMD_MEMORY_FETCH    8'h43
`define CMD_DISPLAY_AREA    8'h44
`define CMD_CURSOR_SET      8'h46
`define CMD_CURSOR_GET      8'h47
`define CMD_CURSOR_DIR_BASE 8'h4c
`define CMD_SLEEP           8'h53
`define CMD_DISPLAY_OFF     8'h58
`define CMD_DISPLAY_ON      8'h59
`define CMD_FINE_SHIFT      8'h5a
`define CMD_LAYER_COMBINE   8'h5b
`define CMD_GLYPH_BASE      8'h5c
`define CMD_CURSOR_SHAPE    8'h5d
`define CMD_GRAYSCALE       8'h60

// ****************************************
// Direct-mode read map and fifo
// ****************************************
`define DIRECT_CMD_ADDR     16'h0000
`define DIRECT_IDX_ADDR     16'h0001
`define FIFO_DEPTH          4
`define FIFO_WIDTH          9

`endif

// ### rtl/lcd_port_pkg.sv
package lcd_port_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_RD_WAIT = 5'b00010,
    ST_WR_WAIT = 5'b00100,
    ST_ACKED   = 5'b01000,
    ST_RELEASE = 5'b10000
  } bus_state_t;

  typedef enum logic [1:0] {
    EVT_CMD   = 2'h0,
    EVT_PARAM = 2'h1,
    EVT_DATA  = 2'h2,
    EVT_EXTRA = 2'h3
  } evt_kind_t;

endpackage : lcd_port_pkg

// ### rtl/port_fifo.sv
`timescale 1ns/1ns
module port_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_q != (PW+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : port_fifo

// ### verif/host_cpu_model.sv
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        family_in,
  input  wire logic        pin_fn_in,
  input  wire logic        ack_in,
  input  wire logic        ack_oe_b_in,
  input  wire logic [7:0]  rdata_in,
  output logic             cs_b_out,
  output logic             as_b_out,
  output logic             ds_out,
  output logic             rw_out,
  output logic      [15:0] addr_out,
  output logic      [7:0]  data_out,
  output logic             hung_out
);
  // ****************
  // Idle bus: released lines flip so stale values cannot pass
  // ****************
  task automatic park();
    cs_b_out <= 1'b1;
    as_b_out <= 1'b1;
    ds_out   <= ~family_in;
    rw_out   <= 1'b1;
    addr_out <= ~addr_out;
    data_out <= ~data_out;
  endtask : park

  initial begin
    addr_out = 16'h0000;
    data_out = 8'h00;
    hung_out = 1'b0;
    park();
  end

  // ****************
  // One bus cycle, all qualifiers held until ack is seen
  // ****************
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    cs_b_out <= 1'b0;
    as_b_out <= ~pin_fn_in;
    addr_out <= a;
    data_out <= wr ? d : ~data_out;
    rw_out   <= ~wr;
    ds_out   <= family_in | wr;
    while (!(ack_in === 1'b0 && ack_oe_b_in === 1'b0) && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 100) hung_out <= 1'b1;
    q = rdata_in;
    @(posedge clk_in);
    park();
    repeat (12) @(posedge clk_in);
  endtask : cyc
endmodule : host_cpu_model

// ### verif/lcd_host_port_properties.sv
`timescale 1ns/1ns
module lcd_host_port_properties (
  input wire logic       SYS_CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       HOST_CS_B_IN,
  input wire logic [7:0] HOST_DATA_OUT,
  input wire logic       HOST_DATA_OE_B_OUT,
  input wire logic       HOST_ACK_OUT,
  input wire logic       HOST_ACK_OE_B_OUT,
  input wire logic       MEM_FETCH_PULSE_OUT,
  input wire logic       EVT_VALID_OUT,
  input wire logic       EVT_READY_IN,
  input wire logic [1:0] EVT_KIND_OUT,
  input wire logic [7:0] EVT_DATA_OUT
);
  logic [3:0] gap_q;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  // ****************
  // Edges since the last start, saturating so idle time never wraps
  // ****************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      gap_q <= 4'hf;
    end else if ($fell(HOST_ACK_OE_B_OUT)) begin
      gap_q <= 4'h0;
    end else if (gap_q != 4'hf) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  AST_ACK_STARTS_HIGH : assert property ($fell(HOST_ACK_OE_B_OUT) |-> HOST_ACK_OUT && !HOST_CS_B_IN)
    else $error("Ack enabled without select or high level");
  AST_ACK_RELEASE : assert property ($rose(HOST_ACK_OUT) |=> HOST_ACK_OE_B_OUT)
    else $error("Ack not released one clock after rising");
  AST_ACK_DRIVEN : assert property (!HOST_ACK_OUT |-> !HOST_ACK_OE_B_OUT)
    else $error("Ack low while not driven");
  AST_READ_DRIVE_LATE : assert property ($fell(HOST_DATA_OE_B_OUT) |-> $past(HOST_ACK_OE_B_OUT, 5) == 1'b0)
    else $error("Read data driven too early");
  AST_READ_WITH_ACK : assert property ($fell(HOST_DATA_OE_B_OUT) |-> !HOST_ACK_OUT)
    else $error("Read data driven without ack");
  AST_READ_HELD : assert property (!HOST_DATA_OE_B_OUT && !HOST_ACK_OUT |=>
    $stable(HOST_DATA_OUT) || HOST_DATA_OE_B_OUT)
    else $error("Read data changed while acknowledged");
  AST_FETCH_PULSE : assert property (MEM_FETCH_PULSE_OUT |=> !MEM_FETCH_PULSE_OUT)
    else $error("Fetch pulse longer than one clock");
  AST_EVT_HELD : assert property (EVT_VALID_OUT && !EVT_READY_IN |=>
    EVT_VALID_OUT && $stable(EVT_KIND_OUT) && $stable(EVT_DATA_OUT))
    else $error("Event dropped or changed while stalled");
  AST_CYCLE_SPACING : assert property ($fell(HOST_ACK_OE_B_OUT) |-> gap_q >= 4'h6)
    else $error("Bus cycles started too close together");

  cover property ($fell(HOST_DATA_OE_B_OUT));
  cover property (EVT_VALID_OUT && !EVT_READY_IN);
  cover property (MEM_FETCH_PULSE_OUT);
endmodule : lcd_host_port_properties

bind lcd_host_port lcd_host_port_properties u_props (.SYS_CLK_IN, .RST_B_IN, .HOST_CS_B_IN, .HOST_DATA_OUT,
  .HOST_DATA_OE_B_OUT, .HOST_ACK_OUT, .HOST_ACK_OE_B_OUT, .MEM_FETCH_PULSE_OUT, .EVT_VALID_OUT, .EVT_READY_IN,
  .EVT_KIND_OUT, .EVT_DATA_OUT);

// ### verif/test_lcd_host_bus_port_and_command_decode.sv
`timescale 1ns/1ns
module test_lcd_host_bus_port_and_command_decode;
  logic       clk        = 1'b0;
  logic       rst_b      = 1'b0;
  logic       mode       = 1'b1;
  logic       family     = 1'b1;
  logic       pin_fn     = 1'b1;
  logic       evt_ready  = 1'b1;
  logic [7:0] mem_rdata  = 8'h3c;
  logic [7:0] q;
  logic [1:0] ev_kind;
  logic [7:0] ev_code;
  logic [3:0] ev_idx;
  logic [7:0] ev_data;
  int         n_evt      = 0;
  int         n_fetch    = 0;
  int         n0;
  int         mismatches = 0;
  int         num_checks = 0;
  logic [7:0] codes [11] = '{8'h40, 8'h44, 8'h5d, 8'h5c, 8'h5a, 8'h5b, 8'h46, 8'h59, 8'h53, 8'h60, 8'h4c};
  logic [3:0] counts [11] = '{4'h8, 4'ha, 4'h2, 4'h2, 4'h1, 4'h1, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0};
  wire        cs_b, as_b, ds, rw, ack, ack_oe_b, data_oe_b, hung, fetch, evt_valid, disp_on, sleep, gray;
  wire [15:0] addr, cursor;
  wire [7:0]  wdata, rdata, evt_code, evt_data;
  wire [1:0]  evt_kind, dir;
  wire [3:0]  evt_idx;

  always #4 clk = ~clk;

  lcd_host_port DUT (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .HOST_CS_B_IN(cs_b), .HOST_AS_B_IN(as_b),
    .HOST_DS_IN(ds), .HOST_RW_IN(rw), .HOST_ADDRESS_LINES_IN(addr), .HOST_DATA_IN(wdata),
    .HOST_DATA_OUT(rdata), .HOST_DATA_OE_B_OUT(data_oe_b), .HOST_ACK_OUT(ack), .HOST_ACK_OE_B_OUT(ack_oe_b),
    .ACCESS_MODE_STRAP_IN(mode), .BUS_FAMILY_STRAP_IN(family), .PIN_FUNCTION_STRAP_IN(pin_fn),
    .MEM_RDATA_IN(mem_rdata), .MEM_FETCH_PULSE_OUT(fetch), .EVT_VALID_OUT(evt_valid), .EVT_READY_IN(evt_ready),
    .EVT_KIND_OUT(evt_kind), .EVT_CODE_OUT(evt_code), .EVT_INDEX_OUT(evt_idx), .EVT_DATA_OUT(evt_data),
    .DISPLAY_ON_OUT(disp_on), .SLEEP_OUT(sleep), .CURSOR_DIR_OUT(dir), .GRAYSCALE_OUT(gray),
    .CURSOR_ADDR_OUT(cursor));

  host_cpu_model host (.clk_in(clk), .family_in(family), .pin_fn_in(pin_fn), .ack_in(ack),
    .ack_oe_b_in(ack_oe_b), .rdata_in(rdata), .cs_b_out(cs_b), .as_b_out(as_b), .ds_out(ds), .rw_out(rw),
    .addr_out(addr), .data_out(wdata), .hung_out(hung));

  // ****************
  // Event sink and hang watch
  // ****************
  always @(posedge clk) begin
    if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
      n_evt++;
      ev_kind = evt_kind;
      ev_code = evt_code;
      ev_idx  = evt_idx;
      ev_data = evt_data;
    end
    if (fetch === 1'b1) n_fetch++;
    if (hung === 1'b1) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic restart(input logic m, input logic f, input logic p);
    @(posedge clk);
    rst_b  <= 1'b0;
    mode   <= m;
    family <= f;
    pin_fn <= p;
    @(posedge clk);
    host.park();
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : restart

  task automatic cmd(input logic [7:0] d);
    host.cyc(1'b1, 16'h0001, d, q);
  endtask : cmd

  task automatic par(input logic [7:0] d);
    host.cyc(1'b1, 16'h0000, d, q);
  endtask : par

  task automatic rd(input logic [15:0] a);
    host.cyc(1'b0, a, 8'h00, q);
  endtask : rd

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // ****************
  // Sequence
  // ****************
  initial begin
    restart(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 11; i++) begin
      cmd(codes[i]);
      check("cmd", 16'({ev_kind, ev_code}), 16'({lcd_port_pkg::EVT_CMD, codes[i]}));
      for (int j = 0; j < counts[i]; j++) par(8'(j));
      if (counts[i] > 4'h0) check("param", 16'({ev_kind, ev_idx}), 16'({lcd_port_pkg::EVT_PARAM, counts[i] - 4'h1}));
      par(8'h77);
      check("extra", 16'(ev_kind), 16'(lcd_port_pkg::EVT_EXTRA));
    end
    $display("Command table done");
    cmd(8'h53);
    check("sleep", 16'(sleep), 16'h0001);
    cmd(8'h40);
    check("sleep", 16'(sleep), 16'h0000);
    cmd(8'h59);
    check("display", 16'(disp_on), 16'h0001);
    cmd(8'h58);
    check("display", 16'(disp_on), 16'h0000);
    cmd(8'h60);
    check("gray", 16'(gray), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      cmd(8'h4c + 8'(k));
      check("direction", 16'(dir), 16'(k));
    end
    cmd(8'h46);
    par(8'h34);
    par(8'h12);
    check("cursor", cursor, 16'h1234);
    cmd(8'h47);
    rd(16'h0001);
    check("cursor low", 16'(q), 16'h0034);
    rd(16'hfff1);
    check("cursor high", 16'(q), 16'h0012);
    rd(16'h0000);
    check("select zero", 16'(q), 16'h0000);
    $display("Levels and cursor done");
    cmd(8'h43);
    rd(16'h0001);
    check("fetch", 16'(q), 16'h003c);
    mem_rdata <= 8'ha5;
    rd(16'h0001);
    check("fetch", {q, 8'(n_fetch)}, 16'ha502);
    cmd(8'h44);
    par(8'h01);
    cmd(8'h5d);
    par(8'h02);
    check("cut short", 16'({ev_code, ev_kind, ev_idx}), 16'({8'h5d, lcd_port_pkg::EVT_PARAM, 4'h0}));
    cmd(8'h42);
    n0 = n_evt;
    evt_ready <= 1'b0;
    for (int j = 0; j < 5; j++) par(8'(j));
    fork
      begin
        repeat (60) @(posedge clk);
        evt_ready <= 1'b1;
      end
      par(8'h55);
    join
    check("stream", 16'({ev_kind, ev_data}), 16'({lcd_port_pkg::EVT_DATA, 8'h55}));
    check("stream count", 16'(n_evt - n0), 16'h0006);
    $display("Memory and stall done");
    restart(1'b0, 1'b0, 1'b0);
    host.cyc(1'b1, 16'h0000, 8'h5a, q);
    host.cyc(1'b1, 16'h0abc, 8'h21, q);
    check("direct param", 16'({ev_kind, ev_code}), 16'({lcd_port_pkg::EVT_PARAM, 8'h5a}));
    rd(16'h0000);
    check("direct cmd", 16'(q), 16'h005a);
    rd(16'h0002);
    check("direct other", 16'(q), 16'h0000);
    rd(16'h0001);
    check("direct index", 16'(q), 16'h0001);
    restart(1'b0, 1'b1, 1'b1);
    host.cyc(1'b1, 16'h0000, 8'h60, q);
    check("direct gray", 16'(gray), 16'h0001);
    rd(16'h0000);
    check("direct read", 16'(q), 16'h0060);
    $display("Direct access done");
    complete_run();
  end
endmodule : test_lcd_host_bus_port_and_command_decode
